// ### design/accel_system_control_regs.sv
/*
 System control register bank of a three-axis accelerometer, as a classic
 Wishbone slave. Holds the identification and primary control registers,
 a sample rate timer, low-noise clamping and the burst address pointer.
 Assumes sensor data and sleep state arrive on plain synchronous inputs.
*/
`timescale 1ns/1ps
module accel_system_control_regs (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic auto_sleep,
	input wire logic burst_advance,
	input wire logic [13:0] accel_raw,
	input wire logic [13:0] event_threshold,
	output logic [13:0] accel_out,
	output logic threshold_hit,
	output logic sample_tick,
	output logic [7:0] burst_addr,
	output logic active_mode,
	output logic low_noise
);
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK = 2'b10
	} bus_state_t;

	bus_state_t bus_q, bus_d;
	logic [7:0] ctrl_q, ctrl_d;
	logic [7:0] aux_q, aux_d;
	logic [1:0] fifo_q, fifo_d;
	logic [31:0] rdat_q, rdat_d;
	logic [7:0] ptr_q, ptr_d;
	logic [13:0] accel_q, accel_d;
	logic hit_q, hit_d;
	logic reject_q, reject_d;
	logic ack_q, ack_d;
	logic [7:0] index;
	logic wr_ok;
	logic [11:0] mult;
	logic tick;

	// Register index from the word address; byte offset bits are ignored
	assign index = wb_adr_i[9:2];
	assign wr_ok = (bus_q == BUS_IDLE) && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];

	// Rate code to period multiple of the 1.25 ms base; 2^code except top codes
	function automatic logic [11:0] dr_mult(input logic [2:0] code);
		unique case (code)
			3'h0: dr_mult = sysctl_pkg::MULT_DR0;
			3'h1: dr_mult = sysctl_pkg::MULT_DR1;
			3'h2: dr_mult = sysctl_pkg::MULT_DR2;
			3'h3: dr_mult = sysctl_pkg::MULT_DR3;
			3'h4: dr_mult = sysctl_pkg::MULT_DR4;
			3'h5: dr_mult = sysctl_pkg::MULT_DR5;
			3'h6: dr_mult = sysctl_pkg::MULT_DR6;
			3'h7: dr_mult = sysctl_pkg::MULT_DR7;
		endcase
	endfunction

	// Sleep poll code to the same multiple: 50, 12.5, 6.25, 1.56 Hz
	function automatic logic [11:0] sleep_mult(input logic [1:0] code);
		unique case (code)
			2'h0: sleep_mult = dr_mult(3'h4);
			2'h1: sleep_mult = dr_mult(3'h5);
			2'h2: sleep_mult = dr_mult(3'h6);
			2'h3: sleep_mult = dr_mult(3'h7);
		endcase
	endfunction

	// Effective sample period: sleep overrides, temperature doubles
	always_comb begin
		mult = auto_sleep ? sleep_mult(ctrl_q[sysctl_pkg::ASLP_LSB +: 2])
			: dr_mult(ctrl_q[sysctl_pkg::DR_LSB +: 3]);
		if (aux_q == sysctl_pkg::AUX_TEMP_ON) begin
			mult = {mult[10:0], 1'b0};
		end
	end

	rate_timer #(
		.BASE(sysctl_pkg::BASE_CYCLES)
	) u_timer (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.run(ctrl_q[sysctl_pkg::ACTIVE_BIT]),
		.mult(mult),
		.tick(tick)
	);

	// Register writes; CTRL fields other than active freeze while Active
	always_comb begin
		ctrl_d = ctrl_q;
		aux_d = aux_q;
		fifo_d = fifo_q;
		reject_d = reject_q;
		if (wr_ok) begin
			unique case (index)
				sysctl_pkg::CTRL_INDEX: begin
					ctrl_d[sysctl_pkg::ACTIVE_BIT] = wb_dat_i[sysctl_pkg::ACTIVE_BIT];
					if (!ctrl_q[sysctl_pkg::ACTIVE_BIT]) begin
						ctrl_d[7:2] = wb_dat_i[7:2];
						if (fifo_q == sysctl_pkg::FIFO_MODE_OFF) begin
							ctrl_d[sysctl_pkg::FREAD_BIT] = wb_dat_i[sysctl_pkg::FREAD_BIT];
						end
					end
					// Sticky flag shows a field change dropped while Active; reads back for debug
					if ((wb_dat_i[7:1] != ctrl_q[7:1]) && ctrl_q[sysctl_pkg::ACTIVE_BIT]) begin
						reject_d = 1'b1;
					end
				end
				sysctl_pkg::AUX_INDEX: aux_d = wb_dat_i[7:0];
				sysctl_pkg::FIFO_INDEX: fifo_d = wb_dat_i[1:0];
				sysctl_pkg::STATUS_INDEX: reject_d = 1'b0;
				default: ;
			endcase
		end
	end

	// Bus handshake: one wait state, ack for a single cycle
	always_comb begin
		bus_d = bus_q;
		rdat_d = rdat_q;
		ack_d = 1'b0;
		unique case (bus_q)
			BUS_IDLE: begin
				if (wb_cyc_i && wb_stb_i) begin
					bus_d = BUS_ACK;
					ack_d = 1'b1;
					unique case (index)
						sysctl_pkg::ID_INDEX: rdat_d = {24'h000000, sysctl_pkg::PART_ID};
						sysctl_pkg::CTRL_INDEX: rdat_d = {24'h000000, ctrl_q};
						sysctl_pkg::AUX_INDEX: rdat_d = {24'h000000, aux_q};
						sysctl_pkg::FIFO_INDEX: rdat_d = {30'h0, fifo_q};
						sysctl_pkg::STATUS_INDEX: rdat_d = {31'h0, reject_q};
						sysctl_pkg::PTR_INDEX: rdat_d = {24'h000000, ptr_q};
						default: rdat_d = 32'h00000000;
					endcase
				end
			end
			BUS_ACK: bus_d = BUS_IDLE;
			// A corrupted state code falls back to idle rather than hanging the bus
			default: bus_d = BUS_IDLE;
		endcase
	end

	// Burst pointer; fast-read skips low bytes and wraps after Z high
	always_comb begin
		ptr_d = ptr_q;
		if (burst_advance) begin
			if (ctrl_q[sysctl_pkg::FREAD_BIT]) begin
				ptr_d = (ptr_q >= sysctl_pkg::ZLSB_INDEX - 8'h02) ? sysctl_pkg::XMSB_INDEX
					: ptr_q + 8'h02;
			end else begin
				ptr_d = (ptr_q >= sysctl_pkg::ZLSB_INDEX) ? sysctl_pkg::XMSB_INDEX
					: ptr_q + 8'h01;
			end
		end
	end

	// Data path: clamp in low-noise, truncate in fast-read
	always_comb begin
		logic [13:0] mag;
		logic [13:0] val;
		mag = accel_raw[13] ? 14'(-accel_raw) : accel_raw;
		val = accel_raw;
		if (ctrl_q[sysctl_pkg::LNOISE_BIT] && mag > sysctl_pkg::RANGE_LNOISE_MAX) begin
			val = accel_raw[13] ? 14'(-sysctl_pkg::RANGE_LNOISE_MAX)
				: sysctl_pkg::RANGE_LNOISE_MAX;
			mag = sysctl_pkg::RANGE_LNOISE_MAX;
		end
		accel_d = ctrl_q[sysctl_pkg::FREAD_BIT] ? {val[13:6], 6'h00} : val;
		hit_d = (mag >= event_threshold) && (event_threshold != 14'h0000);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_q <= BUS_IDLE;
			ctrl_q <= sysctl_pkg::CTRL_RESET;
			aux_q <= 8'h00;
			fifo_q <= sysctl_pkg::FIFO_MODE_OFF;
			reject_q <= 1'b0;
			rdat_q <= 32'h00000000;
			ptr_q <= sysctl_pkg::XMSB_INDEX;
			accel_q <= 14'h0000;
			hit_q <= 1'b0;
			ack_q <= 1'b0;
		end else begin
			bus_q <= bus_d;
			ctrl_q <= ctrl_d;
			aux_q <= aux_d;
			fifo_q <= fifo_d;
			reject_q <= reject_d;
			rdat_q <= rdat_d;
			ptr_q <= ptr_d;
			accel_q <= accel_d;
			hit_q <= hit_d;
			ack_q <= ack_d;
		end
	end

	assign wb_dat_o = rdat_q;
	assign wb_ack_o = ack_q;
	assign accel_out = accel_q;
	assign threshold_hit = hit_q;
	assign sample_tick = tick;
	assign burst_addr = ptr_q;
	assign active_mode = ctrl_q[sysctl_pkg::ACTIVE_BIT];
	assign low_noise = ctrl_q[sysctl_pkg::LNOISE_BIT];

	property p_active_freeze;
		@(posedge ref_clk) disable iff (!rst_n)
		ctrl_q[sysctl_pkg::ACTIVE_BIT] |=> ctrl_q[7:1] == $past(ctrl_q[7:1]);
	endproperty
	a_active_freeze: assert property (p_active_freeze) else $error("Field changed while Active");

	property p_fread_fifo;
		@(posedge ref_clk) disable iff (!rst_n)
		fifo_q != sysctl_pkg::FIFO_MODE_OFF |=> $stable(ctrl_q[sysctl_pkg::FREAD_BIT]);
	endproperty
	a_fread_fifo: assert property (p_fread_fifo) else $error("Fast-read changed with FIFO on");

	property p_id_read;
		@(posedge ref_clk) disable iff (!rst_n)
		bus_q == BUS_IDLE && wb_cyc_i && wb_stb_i && index == sysctl_pkg::ID_INDEX
			|=> wb_ack_o && wb_dat_o[7:0] == sysctl_pkg::PART_ID;
	endproperty
	a_id_read: assert property (p_id_read) else $error("Identifier read wrong");

	property p_fread_byte;
		@(posedge ref_clk) disable iff (!rst_n)
		ctrl_q[sysctl_pkg::FREAD_BIT] && $stable(ctrl_q) |=> accel_out[5:0] == 6'h00;
	endproperty
	a_fread_byte: assert property (p_fread_byte) else $error("Low bits in fast-read");

	property p_lnoise_clamp;
		@(posedge ref_clk) disable iff (!rst_n)
		ctrl_q[sysctl_pkg::LNOISE_BIT] && $stable(ctrl_q) && !accel_raw[13]
			|=> accel_out <= sysctl_pkg::RANGE_LNOISE_MAX;
	endproperty
	a_lnoise_clamp: assert property (p_lnoise_clamp) else $error("Range over 4 g");

	property p_thresh_unreached;
		@(posedge ref_clk) disable iff (!rst_n)
		ctrl_q[sysctl_pkg::LNOISE_BIT] && event_threshold > sysctl_pkg::RANGE_LNOISE_MAX
			|=> !threshold_hit;
	endproperty
	a_thresh_unreached: assert property (p_thresh_unreached) else $error("High threshold hit");

	property p_fread_skip;
		@(posedge ref_clk) disable iff (!rst_n)
		burst_advance && ctrl_q[sysctl_pkg::FREAD_BIT] |=> !burst_addr[0] == 1'b0;
	endproperty
	a_fread_skip: assert property (p_fread_skip) else $error("Pointer on a low byte");

	property p_standby_stop;
		@(posedge ref_clk) disable iff (!rst_n)
		!ctrl_q[sysctl_pkg::ACTIVE_BIT] ##1 !ctrl_q[sysctl_pkg::ACTIVE_BIT] |=> !sample_tick;
	endproperty
	a_standby_stop: assert property (p_standby_stop) else $error("Tick in Standby");

	property p_ack_one;
		@(posedge ref_clk) disable iff (!rst_n)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("Ack longer than one cycle");

	// Sleep poll code 00 replaces whatever data rate is selected
	property p_sleep_override;
		@(posedge ref_clk) disable iff (!rst_n)
		auto_sleep && aux_q != sysctl_pkg::AUX_TEMP_ON && ctrl_q[sysctl_pkg::ASLP_LSB +: 2] == 2'h0
			|-> mult == sysctl_pkg::MULT_DR4;
	endproperty
	a_sleep_override: assert property (p_sleep_override) else $error("Sleep rate not used");

	property p_poll_slow;
		@(posedge ref_clk) disable iff (!rst_n)
		auto_sleep && aux_q != sysctl_pkg::AUX_TEMP_ON && ctrl_q[sysctl_pkg::ASLP_LSB +: 2] == 2'h3
			|-> mult == sysctl_pkg::MULT_DR7;
	endproperty
	a_poll_slow: assert property (p_poll_slow) else $error("Slowest poll rate wrong");

	// Temperature on turns the 800 Hz period into the 400 Hz one
	property p_temp_half;
		@(posedge ref_clk) disable iff (!rst_n)
		aux_q == sysctl_pkg::AUX_TEMP_ON && !auto_sleep && ctrl_q[sysctl_pkg::DR_LSB +: 3] == 3'h0
			|-> mult == sysctl_pkg::MULT_DR1;
	endproperty
	a_temp_half: assert property (p_temp_half) else $error("Rate not halved");

	property p_reject_hold;
		@(posedge ref_clk) disable iff (!rst_n)
		reject_q && !(wr_ok && index == sysctl_pkg::STATUS_INDEX) |=> reject_q;
	endproperty
	a_reject_hold: assert property (p_reject_hold) else $error("Reject flag lost");

	// After the Z high byte a fast-read burst starts over at X high
	property p_ptr_wrap;
		@(posedge ref_clk) disable iff (!rst_n)
		burst_advance && ctrl_q[sysctl_pkg::FREAD_BIT] && burst_addr == sysctl_pkg::ZLSB_INDEX - 8'h01
			|=> burst_addr == sysctl_pkg::XMSB_INDEX;
	endproperty
	a_ptr_wrap: assert property (p_ptr_wrap) else $error("Pointer did not wrap");
endmodule

// ### design/rate_timer.sv
/*
 Sample tick generator: one pulse per output sample period.
 Assumes the base period count and a power-of-two multiplier from the bank.
*/
`timescale 1ns/1ps
module rate_timer #(
	parameter int BASE = 50000
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic [11:0] mult,
	output logic tick
);
	logic [16:0] base_q, base_d;
	logic [11:0] mul_q, mul_d;
	logic tick_d;
	localparam logic [16:0] BASE_LAST = 17'(BASE - 1);

	// Base prescaler then period multiplier; stops in Standby
	always_comb begin
		base_d = base_q;
		mul_d = mul_q;
		tick_d = 1'b0;
		if (!run) begin
			base_d = '0;
			mul_d = '0;
		end else if (base_q == BASE_LAST) begin
			base_d = '0;
			if (mul_q >= mult - 12'h001) begin
				mul_d = '0;
				tick_d = 1'b1;
			end else begin
				mul_d = mul_q + 12'h001;
			end
		end else begin
			base_d = base_q + 17'h00001;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			base_q <= '0;
			mul_q <= '0;
			tick <= 1'b0;
		end else begin
			base_q <= base_d;
			mul_q <= mul_d;
			tick <= tick_d;
		end
	end
endmodule

// ### shared/sysctl_pkg.sv
/*
 Constants for the accelerometer system control register bank: register
 offsets, field positions, reset values and rate timing.
 Assumes a 40 MHz ref_clk and a classic Wishbone slave with byte addressing.
*/
package sysctl_pkg;
	localparam logic [7:0] ID_INDEX = 8'h0d;
	localparam logic [7:0] CTRL_INDEX = 8'h2a;
	localparam logic [7:0] AUX_INDEX = 8'h2b;
	localparam logic [7:0] FIFO_INDEX = 8'h2c;
	localparam logic [7:0] STATUS_INDEX = 8'h2d;
	localparam logic [7:0] PTR_INDEX = 8'h2e;
	localparam logic [7:0] XMSB_INDEX = 8'h01;
	localparam logic [7:0] ZLSB_INDEX = 8'h06;
	// Identifier is arbitrary
	localparam logic [7:0] PART_ID = 8'h5c;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] AUX_TEMP_ON = 8'h03;
	// Sample period in base periods per rate code; 800 Hz is one base period
	localparam logic [11:0] MULT_DR0 = 12'h001;
	localparam logic [11:0] MULT_DR1 = 12'h002;
	localparam logic [11:0] MULT_DR2 = 12'h004;
	localparam logic [11:0] MULT_DR3 = 12'h008;
	localparam logic [11:0] MULT_DR4 = 12'h010;
	localparam logic [11:0] MULT_DR5 = 12'h040;
	localparam logic [11:0] MULT_DR6 = 12'h080;
	localparam logic [11:0] MULT_DR7 = 12'h200;
	localparam int ACTIVE_BIT = 0;
	localparam int FREAD_BIT = 1;
	localparam int LNOISE_BIT = 2;
	localparam int DR_LSB = 3;
	localparam int ASLP_LSB = 6;
	localparam logic [1:0] FIFO_MODE_OFF = 2'h0;
	localparam logic [13:0] RANGE_LNOISE_MAX = 14'h1000;
	// Period of the fastest rate, 1.25 ms, in nanoseconds
	localparam int BASE_PERIOD_NS = 1250000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int BASE_CYCLES = BASE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int DIV_W = 12;
endpackage

// ### tb/accel_system_control_regs_tb.sv
/*
 Self-checking bench for the system control register bank.
 Assumes the host model drives the bus; sensor inputs are driven here.
*/
`timescale 1ns/1ps
module accel_system_control_regs_tb;
	logic ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, timed_out;
	logic [9:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic auto_sleep, burst_advance, threshold_hit, sample_tick;
	logic active_mode, low_noise;
	logic [13:0] accel_raw, event_threshold, accel_out;
	logic [7:0] burst_addr;
	int failures = 0;
	int samples_checked = 0;
	int tick_wait;

	accel_system_control_regs dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .auto_sleep(auto_sleep),
		.burst_advance(burst_advance), .accel_raw(accel_raw),
		.event_threshold(event_threshold), .accel_out(accel_out),
		.threshold_hit(threshold_hit), .sample_tick(sample_tick),
		.burst_addr(burst_addr), .active_mode(active_mode), .low_noise(low_noise));
	host_bus_model host_u (.ref_clk(ref_clk), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .timed_out(timed_out));

	// 40 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic summarize;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	// A hung bus ends the run at once
	task automatic acc(input logic we, input logic [7:0] idx, input logic [7:0] wd,
		output logic [31:0] rd);
		host_u.bus_cycle(we, idx, wd, rd);
		if (timed_out) begin
			failures++;
			summarize();
		end
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
		logic [31:0] v;
		acc(1'b1, idx, wd, v);
	endtask

	task automatic rd_chk(input string name, input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] v;
		acc(1'b0, idx, 8'h00, v);
		check(name, exp, v);
	endtask

	// Feed one sample and let the output register settle
	task automatic sample(input logic [13:0] raw);
		accel_raw <= raw;
		repeat (4) @(posedge ref_clk);
	endtask

	task automatic advance;
		burst_advance <= 1'b1;
		@(posedge ref_clk);
		burst_advance <= 1'b0;
		@(posedge ref_clk);
	endtask

	// Overall hang guard
	initial begin
		repeat (100000) @(posedge ref_clk);
		failures++;
		summarize();
	end

	initial begin
		rst_n = 1'b0;
		auto_sleep = 1'b0;
		burst_advance = 1'b0;
		accel_raw = 14'h0000;
		event_threshold = 14'h1001;
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		rd_chk("ctrl_reset", sysctl_pkg::CTRL_INDEX, 32'h0);
		check("active_reset", 32'h0, {31'h0, active_mode});
		check("burst_reset", 32'h1, {24'h0, burst_addr});
		rd_chk("id", sysctl_pkg::ID_INDEX, {24'h0, sysctl_pkg::PART_ID});
		wr(sysctl_pkg::ID_INDEX, ~sysctl_pkg::PART_ID);
		rd_chk("id_kept", sysctl_pkg::ID_INDEX, {24'h0, sysctl_pkg::PART_ID});
		rd_chk("unmapped", 8'h3f, 32'h0);
		sample(14'h1fff);
		check("out_full", 32'h1fff, {18'h0, accel_out});
		check("hit_normal", 32'h1, {31'h0, threshold_hit});
		// Low-noise plus fast-read, set while in Standby
		wr(sysctl_pkg::CTRL_INDEX, 8'h06);
		rd_chk("ctrl_06", sysctl_pkg::CTRL_INDEX, 32'h06);
		check("low_noise", 32'h1, {31'h0, low_noise});
		sample(14'h1fff);
		check("clamp_pos", 32'h1000, {18'h0, accel_out});
		check("hit_lnoise", 32'h0, {31'h0, threshold_hit});
		sample(14'h2000);
		check("clamp_neg", 32'h3000, {18'h0, accel_out});
		sample(14'h0abc);
		check("msb_only", 32'h0a80, {18'h0, accel_out});
		advance();
		check("burst_y", 32'h3, {24'h0, burst_addr});
		advance();
		check("burst_z", 32'h5, {24'h0, burst_addr});
		advance();
		check("burst_wrap", 32'h1, {24'h0, burst_addr});
		// Active, then a field change that must be dropped
		wr(sysctl_pkg::CTRL_INDEX, 8'h07);
		rd_chk("ctrl_active", sysctl_pkg::CTRL_INDEX, 32'h07);
		check("active_on", 32'h1, {31'h0, active_mode});
		wr(sysctl_pkg::CTRL_INDEX, 8'hf9);
		rd_chk("ctrl_kept", sysctl_pkg::CTRL_INDEX, 32'h07);
		rd_chk("reject_flag", sysctl_pkg::STATUS_INDEX, 32'h1);
		wr(sysctl_pkg::CTRL_INDEX, 8'h06);
		// Fast-read locked while FIFO mode is non-zero
		wr(sysctl_pkg::FIFO_INDEX, 8'h01);
		wr(sysctl_pkg::CTRL_INDEX, 8'h04);
		rd_chk("fread_locked", sysctl_pkg::CTRL_INDEX, 32'h06);
		wr(sysctl_pkg::FIFO_INDEX, 8'h00);
		wr(sysctl_pkg::CTRL_INDEX, 8'h04);
		rd_chk("fread_free", sysctl_pkg::CTRL_INDEX, 32'h04);
		// Auto-Sleep with poll codes 00 and 11; the rate asserts watch the period
		auto_sleep <= 1'b1;
		wr(sysctl_pkg::CTRL_INDEX, 8'hc4);
		rd_chk("ctrl_poll", sysctl_pkg::CTRL_INDEX, 32'hc4);
		auto_sleep <= 1'b0;
		// Tick rises one base period after the taking edge; wr returns two edges later
		wr(sysctl_pkg::CTRL_INDEX, 8'h05);
		tick_wait = 0;
		do begin
			@(posedge ref_clk);
			tick_wait++;
		end while (sample_tick !== 1'b1 && tick_wait < sysctl_pkg::BASE_CYCLES + 100);
		if (sample_tick !== 1'b1) begin
			failures++;
			summarize();
		end
		check("tick_period", sysctl_pkg::BASE_CYCLES - 1, tick_wait);
		wr(sysctl_pkg::CTRL_INDEX, 8'h04);
		rd_chk("ctrl_standby", sysctl_pkg::CTRL_INDEX, 32'h04);
		wr(sysctl_pkg::STATUS_INDEX, 8'h00);
		rd_chk("reject_clear", sysctl_pkg::STATUS_INDEX, 32'h0);
		wr(sysctl_pkg::AUX_INDEX, sysctl_pkg::AUX_TEMP_ON);
		rd_chk("aux", sysctl_pkg::AUX_INDEX, 32'h03);
		summarize();
	end
endmodule

// ### tb/host_bus_model.sv
/*
 Host side of the register bus: a classic Wishbone master with one task.
 Assumes the slave answers with a registered ack and keeps read data for it.
*/
`timescale 1ns/1ps
module host_bus_model (
	input wire logic ref_clk,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	output logic wb_cyc_i,
	output logic wb_stb_i,
	output logic wb_we_i,
	output logic [9:0] wb_adr_i,
	output logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_i,
	output logic timed_out
);
	// Idle bus at time zero
	initial begin
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 10'h000;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h00000000;
		timed_out = 1'b0;
	end

	// One cycle, held until ack is sampled; the bench also sends field
	// changes while Active and fast-read changes with FIFO mode non-zero
	task automatic bus_cycle(input logic we, input logic [7:0] idx,
		input logic [7:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {idx, 2'b00};
		wb_sel_i <= 4'h1;
		wb_dat_i <= {24'h000000, wd};
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		rd = wb_dat_o;
		timed_out = (wb_ack_o !== 1'b1);
		// Released data shows a changed pattern, not the old value
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_dat_i <= ~wb_dat_i;
		@(posedge ref_clk);
	endtask
endmodule
